// *** logic/spc_port.sv ***
// Added by the designer: register access over AHB-Lite.
`timescale 1ns/1ps

module spc_port
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	output spc_pkg::spc_stat_s status_o,
	output logic port_irq_o,
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe_o,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe_o,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe_o,
	input wire logic cs_n_i,
	output logic cs_n_o,
	output logic cs_n_oe_o
);
	import spc_pkg::*;

	// ------------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------------
	logic [15:0] con;
	logic [7:0] div;
	logic [7:0] rx_buf;
	logic [7:0] tx_buf;
	logic [7:0] last_tx;
	logic tx_full;
	logic tx_udf;
	logic rx_full;
	logic rx_ovf;
	logic read_req;
	spc_ctrl_s ctrl;
	spc_stat_s stat;

	assign ctrl = spc_ctrl_s'(con);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	logic dp_write;
	logic [31:0] dp_addr;
	logic ap_valid;
	logic ap_read;
	logic rd_rx;
	logic wr_tx;
	logic wr_div;
	logic wr_con;
	logic [31:0] rd_data;

	assign ap_valid = hsel_i & htrans_i[1] & hready_i;
	assign ap_read = ap_valid & ~hwrite_i;
	assign rd_rx = ap_read & (haddr_i == SPC_ADDR_RX);
	assign wr_tx = dp_write & (dp_addr == SPC_ADDR_TX);
	assign wr_div = dp_write & (dp_addr == SPC_ADDR_DIV);
	assign wr_con = dp_write & (dp_addr == SPC_ADDR_CON);

	// The transmit byte reads as zero; unmapped words read as zero.
	assign rd_data =
		(haddr_i == SPC_ADDR_STATUS) ? {SPC_PAD24, stat} :
		(haddr_i == SPC_ADDR_RX) ? {SPC_PAD24, rx_buf} :
		(haddr_i == SPC_ADDR_DIV) ? {SPC_PAD24, div} :
		(haddr_i == SPC_ADDR_CON) ? {SPC_PAD16, con} :
		SPC_WORD_ZERO;

	assign hreadyout_o = 1'b1;
	assign hresp_o = SPC_HRESP_OKAY;

	// ------------------------------------------------------------------
	// Status
	// ------------------------------------------------------------------
	assign stat.rsv = SPC_STAT_RSV;
	assign stat.rx_ovf = rx_ovf;
	assign stat.rx_irq = rx_full | rx_ovf;
	assign stat.rx_full = rx_full;
	assign stat.tx_udf = tx_udf;
	assign stat.tx_irq = ~tx_full | tx_udf;
	assign stat.tx_pend = tx_full;
	assign status_o = stat;
	assign port_irq_o = ctrl.enable &
		(ctrl.tx_mode ? stat.tx_irq : stat.rx_irq);

	// ------------------------------------------------------------------
	// Shift engine
	// ------------------------------------------------------------------
	spc_state_e state;
	spc_state_e next_state;
	logic half;
	logic [2:0] cnt;
	logic [1:0] stall_cnt;
	logic [7:0] tx_sh;
	logic [7:0] rx_sh;
	logic sclk_q;
	logic csn_q;
	logic tick;
	logic en_m;
	logic en_s;
	logic m_tick;
	logic m_sample;
	logic m_shift;
	logic m_end;
	logic m_start;
	logic m_next;
	logic go;
	logic s_act;
	logic s_start;
	logic sclk_edge;
	logic lead;
	logic trail;
	logic s_sample;
	logic s_shift;
	logic sample;
	logic shift;
	logic done;
	logic load;
	logic take;
	logic udf_set;
	logic rx_store;
	logic stall_end;
	logic out_bit;
	logic ser_in;
	logic [7:0] fill;
	logic [7:0] next_rx_sh;
	logic [7:0] next_tx_sh;

	assign en_m = ctrl.enable & ctrl.master;
	assign en_s = ctrl.enable & ~ctrl.master;

	spc_tick_gen u_tick
	(
		.clock_i(clock_i),
		.reset_i(reset_i),
		.restart_i(state == SPC_IDLE),
		.period_i(div),
		.tick_o(tick)
	);

	// Master: sample at the end of the first half of a bit, shift at the
	// end of the second, for either phase; only the clock shape moves.
	assign m_tick = en_m & (state == SPC_RUN) & tick;
	assign m_sample = m_tick & ~half;
	assign m_shift = m_tick & half & (cnt != SPC_CNT_ZERO);
	assign m_end = m_tick & half & (cnt == SPC_CNT_ZERO);
	assign go = ctrl.tx_mode ? tx_full : read_req;
	assign m_start = en_m & (state == SPC_IDLE) & go;
	assign m_next = m_end & ctrl.cont & tx_full;
	assign stall_end = tick & (stall_cnt == SPC_STALL_LAST);

	// Slave: edges of the external clock, framed by the select input.
	assign s_act = en_s & ~cs_n_i;
	assign s_start = en_s & csn_q & ~cs_n_i;
	assign sclk_edge = sclk_i ^ sclk_q;
	assign lead = sclk_edge & (sclk_i != ctrl.cpol);
	assign trail = sclk_edge & (sclk_i == ctrl.cpol);
	assign s_sample = s_act & (ctrl.cpha ? trail : lead);
	// The first leading edge of a byte in phase 1 must not shift, since
	// the first bit is already presented when the byte is loaded.
	assign s_shift = s_act & (ctrl.cpha ? lead : trail) &
		(cnt != SPC_CNT_ZERO);

	assign sample = m_sample | s_sample;
	assign shift = m_shift | s_shift;
	assign done = sample & (cnt == SPC_CNT_LAST);
	assign load = m_start | m_next | s_start | (done & s_act);
	assign take = load & tx_full;
	assign udf_set = load & ~tx_full;
	assign fill = tx_full ? tx_buf :
		(ctrl.udf_zero ? SPC_UDF_FILL : last_tx);

	assign out_bit = ctrl.lsb_first ? tx_sh[0] : tx_sh[7];
	assign ser_in = ctrl.loop ? out_bit :
		(ctrl.master ? miso_i : mosi_i);
	assign next_rx_sh = ctrl.lsb_first ? {ser_in, rx_sh[7:1]} :
		{rx_sh[6:0], ser_in};
	assign next_tx_sh = ctrl.lsb_first ? {1'b0, tx_sh[7:1]} :
		{tx_sh[6:0], 1'b0};
	// Overflow keeps or drops the new byte; a read in the same cycle
	// makes room, so the byte is kept then.
	assign rx_store = done & (~rx_full | rd_rx | ctrl.ovw);

	always_comb
	begin
		next_state = state;
		unique case (state)
			SPC_IDLE:
				if (m_start)
					next_state = SPC_RUN;
			SPC_RUN:
				if (m_end && !m_next)
					next_state = ctrl.cont ? SPC_IDLE : SPC_STALL;
			SPC_STALL:
				if (stall_end)
					next_state = SPC_IDLE;
		endcase
		if (!en_m)
			next_state = SPC_IDLE;
	end

	// ------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------
	assign sclk_o = (state == SPC_RUN) ?
		(ctrl.cpol ^ (ctrl.cpha ? ~half : half)) : ctrl.cpol;
	assign sclk_oe_o = en_m;
	assign cs_n_o = (state != SPC_RUN);
	assign cs_n_oe_o = en_m & ctrl.cs_en;
	assign mosi_o = out_bit;
	assign mosi_oe_o = en_m;
	assign miso_o = out_bit;
	assign miso_oe_o = en_s & ctrl.sout_en & ~cs_n_i;

	// ------------------------------------------------------------------
	// Flip-flops
	// ------------------------------------------------------------------
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			dp_write <= 1'b0;
			dp_addr <= SPC_WORD_ZERO;
			hrdata_o <= SPC_WORD_ZERO;
		end
		else
		begin
			dp_write <= ap_valid & hwrite_i;
			if (ap_valid)
				dp_addr <= haddr_i;
			if (ap_read)
				hrdata_o <= rd_data;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			con <= SPC_CON_RESET;
			div <= SPC_DIV_RESET;
			tx_buf <= SPC_TX_RESET;
		end
		else
		begin
			if (wr_con)
				con <= hwdata_i[15:0] & SPC_CON_WMASK;
			if (wr_div)
				div <= hwdata_i[7:0];
			if (wr_tx)
				tx_buf <= hwdata_i[7:0];
		end
	end

	// Every set below but that of rx_ovf wins over a clear that lands in the same cycle; a receive read blocks the overflow set.
	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tx_full <= 1'b0;
			tx_udf <= 1'b0;
			rx_full <= 1'b0;
			rx_ovf <= 1'b0;
			read_req <= 1'b0;
		end
		else
		begin
			tx_full <= (tx_full & ~take) | wr_tx;
			tx_udf <= (tx_udf & ~wr_tx) | udf_set;
			rx_full <= (rx_full & ~rd_rx) | done;
			rx_ovf <= (rx_ovf & ~rd_rx) | (done & rx_full & ~rd_rx);
			read_req <= (read_req & ~m_start) |
				(rd_rx & en_m & ~ctrl.tx_mode);
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			rx_buf <= SPC_RX_RESET;
			last_tx <= SPC_TX_RESET;
			tx_sh <= SPC_BYTE_ZERO;
			rx_sh <= SPC_BYTE_ZERO;
		end
		else
		begin
			if (rx_store)
				rx_buf <= next_rx_sh;
			if (take)
				last_tx <= tx_buf;
			if (load)
				tx_sh <= fill;
			else if (shift)
				tx_sh <= next_tx_sh;
			if (sample)
				rx_sh <= next_rx_sh;
		end
	end

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state <= SPC_IDLE;
			half <= 1'b0;
			cnt <= SPC_CNT_ZERO;
			stall_cnt <= SPC_STALL_ZERO;
			sclk_q <= 1'b0;
			csn_q <= 1'b1;
		end
		else
		begin
			state <= next_state;
			sclk_q <= sclk_i;
			csn_q <= cs_n_i;
			if (m_start || m_next || !en_m)
				half <= 1'b0;
			else if (m_tick)
				half <= ~half;
			if (!(s_act || en_m) || m_start || s_start)
				cnt <= SPC_CNT_ZERO;
			else if (sample)
				cnt <= cnt + 3'h1;
			if (state != SPC_STALL)
				stall_cnt <= SPC_STALL_ZERO;
			else if (tick)
				stall_cnt <= stall_cnt + 2'h1;
		end
	end

endmodule // spc_port

// *** logic/spc_pkg.sv ***
package spc_pkg;

	// ------------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------------
	localparam logic [31:0] SPC_ADDR_STATUS = 32'hFFFF0A00;
	localparam logic [31:0] SPC_ADDR_RX = 32'hFFFF0A04;
	localparam logic [31:0] SPC_ADDR_TX = 32'hFFFF0A08;
	localparam logic [31:0] SPC_ADDR_DIV = 32'hFFFF0A0C;
	localparam logic [31:0] SPC_ADDR_CON = 32'hFFFF0A10;

	localparam logic [7:0] SPC_RX_RESET = 8'h00;
	localparam logic [7:0] SPC_TX_RESET = 8'h00;
	localparam logic [7:0] SPC_DIV_RESET = 8'h1B;
	localparam logic [15:0] SPC_CON_RESET = 16'h0000;
	localparam logic [15:0] SPC_CON_WMASK = 16'h1FEF;
	localparam logic [7:0] SPC_UDF_FILL = 8'h00;
	localparam logic [7:0] SPC_BYTE_ZERO = 8'h00;
	localparam logic [23:0] SPC_PAD24 = 24'h000000;
	localparam logic [15:0] SPC_PAD16 = 16'h0000;
	localparam logic [31:0] SPC_WORD_ZERO = 32'h00000000;
	localparam logic [1:0] SPC_STAT_RSV = 2'h0;

	// ------------------------------------------------------------------
	// Timing and counts
	// ------------------------------------------------------------------
	localparam logic [2:0] SPC_CNT_ZERO = 3'h0;
	localparam logic [2:0] SPC_CNT_LAST = 3'h7;
	localparam logic [1:0] SPC_STALL_ZERO = 2'h0;
	// Gap between single-byte transfers: two half periods, one bit time.
	localparam logic [1:0] SPC_STALL_LAST = 2'h1;
	localparam logic SPC_HRESP_OKAY = 1'b0;

	// ------------------------------------------------------------------
	// Field layouts
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] rsv_hi;
		logic cont;
		logic loop;
		logic sout_en;
		logic cs_en;
		logic ovw;
		logic udf_zero;
		logic tx_mode;
		logic lsb_first;
		logic rsv4;
		logic cpol;
		logic cpha;
		logic master;
		logic enable;
	} spc_ctrl_s;

	typedef struct packed {
		logic [1:0] rsv;
		logic rx_ovf;
		logic rx_irq;
		logic rx_full;
		logic tx_udf;
		logic tx_irq;
		logic tx_pend;
	} spc_stat_s;

	typedef enum logic [1:0] {
		SPC_IDLE = 2'b00,
		SPC_RUN = 2'b01,
		SPC_STALL = 2'b11
	} spc_state_e;

endpackage

// *** logic/spc_tick_gen.sv ***
`timescale 1ns/1ps

module spc_tick_gen
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic restart_i,
	input wire logic [7:0] period_i,
	output logic tick_o
);
	import spc_pkg::*;

	logic [7:0] count;

	// A tick every period_i + 1 cycles marks one half of a serial clock.
	assign tick_o = (count == period_i);

	always_ff @(posedge clock_i or posedge reset_i)
	begin
		if (reset_i)
			count <= SPC_BYTE_ZERO;
		else if (restart_i || tick_o)
			count <= SPC_BYTE_ZERO;
		else
			count <= count + 8'h01;
	end

endmodule // spc_tick_gen

// *** bench/spc_port_chk.sv ***
`timescale 1ns/1ps
module spc_port_chk
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_o,
	input wire spc_pkg::spc_stat_s status_o,
	input wire logic port_irq_o,
	input wire logic sclk_oe_o,
	input wire logic mosi_oe_o,
	input wire logic miso_oe_o,
	input wire logic cs_n_i,
	input wire logic cs_n_o
);
	import spc_pkg::*;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	wire take = hsel_i & htrans_i[1] & hready_i;
	wire rd_t = take & !hwrite_i;
	wire wr_tx = take & hwrite_i & (haddr_i == SPC_ADDR_TX);
	property p_hold; !rd_t |=> $stable(hrdata_o); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_rx_clr;
		rd_t && haddr_i == SPC_ADDR_RX |=> !status_o.rx_ovf;
	endproperty
	a_rx_clr: assert property (p_rx_clr) else $error("ovf kept");
	property p_rx_irq;
		status_o.rx_irq == (status_o.rx_full | status_o.rx_ovf);
	endproperty
	a_rx_irq: assert property (p_rx_irq) else $error("rx irq");
	property p_tx_irq;
		status_o.tx_irq == (!status_o.tx_pend | status_o.tx_udf);
	endproperty
	a_tx_irq: assert property (p_tx_irq) else $error("tx irq");
	property p_tx_wr; wr_tx |-> ##2 !status_o.tx_udf; endproperty
	a_tx_wr: assert property (p_tx_wr) else $error("udf kept");
	property p_irq;
		port_irq_o |-> status_o.tx_irq || status_o.rx_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("stray irq");
	property p_m_oe; sclk_oe_o == mosi_oe_o; endproperty
	a_m_oe: assert property (p_m_oe) else $error("master oe");
	property p_s_oe; miso_oe_o |-> !cs_n_i; endproperty
	a_s_oe: assert property (p_s_oe) else $error("slave oe");
	property p_byte; $fell(cs_n_o) |-> !cs_n_o [*8]; endproperty
	a_byte: assert property (p_byte) else $error("short frame");
	c_ovf: cover property (status_o.rx_ovf);
	c_udf: cover property (status_o.tx_udf);
	c_slave: cover property (miso_oe_o);
endmodule // spc_port_chk

bind spc_port spc_port_chk spc_port_chk_i (.clock_i, .reset_i, .hsel_i,
	.haddr_i, .htrans_i, .hwrite_i, .hready_i, .hrdata_o, .status_o,
	.port_irq_o, .sclk_oe_o, .mosi_oe_o, .miso_oe_o, .cs_n_i, .cs_n_o);

// *** bench/spc_slave_model.sv ***
`timescale 1ns/1ps
module spc_slave_model
(
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic mosi_i,
	input wire logic [7:0] resp_i,
	output logic miso_o,
	output logic [7:0] got_o,
	output int nb_o
);
	logic [7:0] sh_o;
	logic [7:0] sh_i;
	int n;
	logic ld;
	initial
	begin
		nb_o = 0;
		sh_o = 8'h00;
		ld = 1'b0;
	end
	// Unselected, the line shows the inverse bit so stale data never passes.
	assign miso_o = cs_n_i ? ~sh_o[7] : sh_o[7];
	always @(negedge cs_n_i)
	begin
		sh_o = resp_i + nb_o[7:0];
		n = 0;
		ld = 1'b0;
	end
	// Idle-low clock, data taken on the leading (rising) edge.
	always @(posedge sclk_i)
		if (!cs_n_i)
		begin
			sh_i = {sh_i[6:0], mosi_i};
			n++;
			if (n == 8)
			begin
				got_o = sh_i;
				nb_o++;
				n = 0;
				ld = 1'b1;
			end
		end
	always @(negedge sclk_i)
		if (!cs_n_i)
		begin
			sh_o = ld ? resp_i + nb_o[7:0] : {sh_o[6:0], 1'b0};
			ld = 1'b0;
		end
endmodule // spc_slave_model

// *** bench/spc_port_tb.sv ***
`timescale 1ns/1ps
module spc_port_tb;
	import spc_pkg::*;
	logic clock_i, reset_i, hwrite, cs_in, irq, sclk, sclk_oe, mosi;
	logic mosi_oe, miso_m, miso_oe, cs_n, cs_oe;
	logic sclk_in, mosi_in, miso_s;
	wire hready;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [7:0] m_got, e, s_got;
	spc_stat_s st;
	int m_nb, n_errors, tests_run, per, lastr, cyc, ncs, k, n;
	spc_port spc_port_i (.clock_i(clock_i), .reset_i(reset_i),
		.hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(hready), .hreadyout_o(hready), .hresp_o(),
		.hrdata_o(hrdata), .status_o(st), .port_irq_o(irq),
		.sclk_i(sclk_in), .sclk_o(sclk), .sclk_oe_o(sclk_oe),
		.mosi_i(mosi_in), .mosi_o(mosi), .mosi_oe_o(mosi_oe),
		.miso_i(miso_m), .miso_o(miso_s), .miso_oe_o(miso_oe),
		.cs_n_i(cs_in), .cs_n_o(cs_n), .cs_n_oe_o(cs_oe));
	spc_slave_model spc_slave_model_i (.sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .resp_i(8'h30), .miso_o(miso_m),
		.got_o(m_got), .nb_o(m_nb));
	initial
	begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	always @(posedge clock_i) cyc <= cyc + 1;
	always @(posedge sclk)
	begin
		per = cyc - lastr;
		lastr = cyc;
	end
	always @(posedge cs_n) ncs++;
	function automatic logic [7:0] rev(input logic [7:0] b);
		for (int i = 0; i < 8; i++)
			rev[i] = b[7 - i];
	endfunction
	task chk(input string nm, input logic [31:0] got, input logic [31:0] ex);
		tests_run++;
		if (got !== ex)
		begin
			n_errors++;
			$display("[FAIL] %s exp %h got %h", nm, ex, got);
		end
	endtask
	task wrap_up();
		$display("errors %0d checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wt(input int nb);
		for (k = 0; k < 3000 && !(m_nb >= nb && cs_n === 1'b1); k++)
			@(posedge clock_i);
		if (k >= 3000)
			chk("timeout", 1, 0);
		if (k >= 3000)
			wrap_up();
	endtask
	// Waits for the next rising edge at which the slave shows ready.
	task hwait();
		int w;
		@(posedge clock_i);
		for (w = 0; w < 100 && hready !== 1'b1; w++)
			@(posedge clock_i);
		if (w >= 100)
			chk("hready", 1, 0);
		if (w >= 100)
			wrap_up();
	endtask
	// The request stays on the bus until it is taken, so it must not
	// wait for the serial link: a held request would be taken again.
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		hwait();
		htrans <= 2'h0;
		hwdata <= d;
		hwait();
		q = hrdata;
	endtask
	task rd(input logic [31:0] a, input logic [31:0] ex, input string nm);
		bus(1'b0, a, 32'h0);
		chk(nm, q, ex);
	endtask
	initial
	begin
		reset_i = 1'b1;
		{htrans, haddr, hwrite, hwdata, cyc} = '0;
		cs_in = 1'b1;
		{sclk_in, mosi_in} = 2'h0;
		n_errors = 0;
		tests_run = 0;
		repeat (4) @(posedge clock_i);
		reset_i <= 1'b0;
		chk("status", st, 8'h02);
		rd(SPC_ADDR_RX, 0, "rx");
		rd(SPC_ADDR_TX, 0, "tx");
		rd(SPC_ADDR_DIV, 32'h1B, "div");
		rd(SPC_ADDR_CON, 0, "con");
		rd(32'hFFFF0A14, 0, "hole");
		bus(1'b1, SPC_ADDR_CON, 32'hFFFF);
		rd(SPC_ADDR_CON, 32'h1FEF, "con rw");
		bus(1'b1, SPC_ADDR_DIV, 32'h1);
		rd(SPC_ADDR_DIV, 32'h1, "div rw");
		for (int l = 0; l < 2; l++)
		begin
			bus(1'b1, SPC_ADDR_CON, 32'h0243 | (l << 5));
			n = m_nb;
			bus(1'b1, SPC_ADDR_TX, 32'hA1);
			wt(n + 1);
			chk("mosi", m_got, l ? 8'h85 : 8'hA1);
			chk("tx irq", irq, 1);
			chk("period", per, 4);
			chk("idle", sclk, 0);
			e = 8'h30 + n[7:0];
			rd(SPC_ADDR_RX, l ? rev(e) : e, "rx");
		end
		bus(1'b1, SPC_ADDR_CON, 32'h0A43);
		n = m_nb;
		bus(1'b1, SPC_ADDR_TX, 32'h5A);
		wt(n + 1);
		rd(SPC_ADDR_RX, 32'h5A, "loop");
		for (int c = 0; c < 2; c++)
		begin
			bus(1'b1, SPC_ADDR_CON, 32'h0243 | (c << 12) | (c << 8));
			n = m_nb;
			ncs = 0;
			bus(1'b1, SPC_ADDR_TX, 32'h11);
			repeat (8) @(posedge clock_i);
			bus(1'b1, SPC_ADDR_TX, 32'h22);
			wt(n + 2);
			chk("frames", ncs, c ? 1 : 2);
			chk("ovf", st.rx_ovf, 1);
			e = 8'h30 + n[7:0] + c[7:0];
			rd(SPC_ADDR_RX, e, "rx ovf");
			chk("ovf clr", st.rx_ovf, 0);
		end
		for (int u = 0; u < 2; u++)
		begin
			bus(1'b1, SPC_ADDR_CON, 32'h0203 | (u << 7));
			n = m_nb;
			bus(1'b0, SPC_ADDR_RX, 32'h0);
			wt(n + 1);
			chk("udf byte", m_got, u ? 0 : 8'h22);
			chk("udf", st.tx_udf, 1);
			chk("rx irq", irq, 1);
			rd(SPC_ADDR_RX, 8'h30 + n[7:0], "rx");
			wt(n + 2);
		end
		bus(1'b1, SPC_ADDR_CON, 32'h0008);
		repeat (2) @(posedge clock_i);
		chk("off clk", sclk, 1);
		chk("off cs", cs_n, 1);
		chk("off oe", sclk_oe, 0);
		bus(1'b1, SPC_ADDR_CON, 32'h0401);
		bus(1'b0, SPC_ADDR_RX, 32'h0);
		bus(1'b1, SPC_ADDR_TX, 32'hC3);
		e = 8'h96;
		// The bench is the external master here, with an idle-low clock
		// that samples on the rising edge, half a bit being two cycles.
		cs_in <= 1'b0;
		for (int b = 7; b >= 0; b--)
		begin
			mosi_in <= e[b];
			repeat (2) @(posedge clock_i);
			sclk_in <= 1'b1;
			s_got = {s_got[6:0], miso_s};
			repeat (2) @(posedge clock_i);
			sclk_in <= 1'b0;
		end
		chk("s oe", miso_oe, 1);
		chk("m oe", mosi_oe, 0);
		cs_in <= 1'b1;
		repeat (2) @(posedge clock_i);
		chk("s tx", s_got, 8'hC3);
		rd(SPC_ADDR_RX, 8'h96, "s rx");
		bus(1'b1, SPC_ADDR_CON, 32'h0003);
		@(posedge clock_i);
		chk("cs oe", cs_oe, 0);
		wrap_up();
	end
endmodule // spc_port_tb
